// [common/sup_ifs.sv]
// carriers between the supervision top and its checkers
`timescale 1ns/100ps
`default_nettype none

interface ct_sum_if;
  import sup_pkg::*;
  logic signed [MAG_W-1:0] phase_re [3];
  logic signed [MAG_W-1:0] phase_im [3];
  logic signed [MAG_W-1:0] earth_re;
  logic signed [MAG_W-1:0] earth_im;
  logic        [MAG_W-1:0] earth_ratio_factor;
  logic        [MAG_W-1:0] dynamic_correction_factor;
  logic        [MAG_W-1:0] deviation;
  logic        [MAG_W-1:0] imax;
  logic                    enable;
  logic                    fault;
  modport top (output phase_re, phase_im, earth_re, earth_im, earth_ratio_factor,
               output dynamic_correction_factor, deviation, imax, enable,
               input fault);
  modport chk (input phase_re, phase_im, earth_re, earth_im, earth_ratio_factor,
               input dynamic_correction_factor, deviation, imax, enable,
               output fault);
endinterface : ct_sum_if

interface rot_if #(parameter int unsigned N = 1);
  import sup_pkg::*;
  logic [MAG_W-1:0] pos_seq [N];
  logic [MAG_W-1:0] neg_seq [N];
  logic [MAG_W-1:0] nominal;
  rotation_t        setting;
  logic [N-1:0]     warn;
  modport top (output pos_seq, neg_seq, nominal, setting, input warn);
  modport chk (input pos_seq, neg_seq, nominal, setting, output warn);
endinterface : rot_if

`default_nettype wire

// [common/sup_pkg.sv]
// constants and helpers for measuring circuit supervision
package sup_pkg;

  localparam int unsigned MAG_W       = 16;
  localparam int unsigned Q_FRAC      = 8;
  localparam int unsigned CLK_PERIOD_NS = 100;

  localparam logic [6:0] PCT_SCALE         = 7'h64;
  localparam logic [6:0] VOLT_LOSS_PCT     = 7'h01;
  localparam logic [6:0] RESID_VOLT_PCT    = 7'h01;
  localparam logic [6:0] NEG_POS_RATIO_PCT = 7'h28;
  localparam logic [6:0] RESID_CURR_PCT    = 7'h0A;
  localparam logic [6:0] ROT_MIN_PCT       = 7'h0A;

  localparam int unsigned COND_PHASE_V  = 0;
  localparam int unsigned COND_SEQ      = 1;
  localparam int unsigned COND_LOAD_I   = 2;
  localparam int unsigned COND_RESID_I  = 3;
  localparam int unsigned COND_NO_OC    = 4;
  localparam int unsigned COND_BREAKER  = 5;
  localparam int unsigned COND_LIVE_BUS = 6;
  localparam int unsigned COND_N        = 7;

  localparam logic [COND_N-1:0] COND_RESET = 7'h00;

  typedef enum logic {
    ROT_ABC,
    ROT_ACB
  } rotation_t;

  // a * pa < b * pb, widened so no product overflows
  function automatic logic scaled_lt(input logic [MAG_W-1:0] a,
                                     input logic [6:0]       pa,
                                     input logic [MAG_W-1:0] b,
                                     input logic [6:0]       pb);
    logic [MAG_W+6:0] lhs;
    logic [MAG_W+6:0] rhs;
    lhs = {7'h00, a} * {{MAG_W{1'b0}}, pa};
    rhs = {7'h00, b} * {{MAG_W{1'b0}}, pb};
    return lhs < rhs;
  endfunction : scaled_lt

endpackage : sup_pkg

// [hw/ct_sum_check.sv]
// earth current consistency check for the current transformers
`timescale 1ns/100ps
`default_nettype none

module ct_sum_check
  import sup_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  ct_sum_if.chk     bus
);

  localparam int unsigned SW = 2 * MAG_W + 2;

  logic signed [2*MAG_W:0]   k_re;
  logic signed [2*MAG_W:0]   k_im;
  logic signed [SW-1:0]      sum_re;
  logic signed [SW-1:0]      sum_im;
  logic        [2*SW-1:0]    sum_sq;
  logic        [2*MAG_W:0]   kd_term;
  logic        [SW-1:0]      limit;
  logic        [2*SW-1:0]    limit_sq;
  logic                      fault_q;

  always_comb begin
    k_re   = ($signed({1'b0, bus.earth_ratio_factor}) * bus.earth_re) >>> Q_FRAC;
    k_im   = ($signed({1'b0, bus.earth_ratio_factor}) * bus.earth_im) >>> Q_FRAC;
    sum_re = SW'(bus.phase_re[0]) + SW'(bus.phase_re[1]) + SW'(bus.phase_re[2]) + SW'(k_re);
    sum_im = SW'(bus.phase_im[0]) + SW'(bus.phase_im[1]) + SW'(bus.phase_im[2]) + SW'(k_im);
    sum_sq = (2*SW)'(unsigned'(sum_re * sum_re)) + (2*SW)'(unsigned'(sum_im * sum_im));
    kd_term  = ({{(MAG_W+1){1'b0}}, bus.dynamic_correction_factor}
               * {{(MAG_W+1){1'b0}}, bus.imax}) >> Q_FRAC;
    limit    = SW'(bus.deviation) + SW'(kd_term);
    limit_sq = {{SW{1'b0}}, limit} * {{SW{1'b0}}, limit};
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= bus.enable && (sum_sq >= limit_sq);
    end
  end

  assign bus.fault = fault_q;

endmodule : ct_sum_check

`default_nettype wire

// [hw/measuring_circuit_supervision.sv]
// loss of potential, fuse failure, ct and rotation supervision top
`timescale 1ns/100ps
`default_nettype none

// Function
// - block only while all measured-quantity loss conditions hold together
// - phase condition: any phase voltage below one percent of nominal
// - residual voltage below one percent, or negative/positive ratio over forty percent
// - all three phase currents below load-current threshold
// - residual current below ten percent of rated current
// - picked-up overcurrent blockers suppress the potential block
// - assigned breaker must be closed; unassigned breaker ignored
// - dead busbar from offline detection withholds the block
// - block alarm only after conditions persist for alarm delay
// - block reaches elements only when block enable is active
// - selected elements blocked while block asserted; others untouched
// - assigned phase VT breaker input signals fuse failure, blocks selected
// - separate earth VT fuse input with same blocking effect
// - user assigns overcurrent alarms as blockers of loss detection
// - ct fault from computed versus measured earth current comparison
// - fault when summed residual reaches deviation plus factor times maximum
// - rotation per input derived from positive and negative sequence
// - one rotation warning per ct and vt on mismatch
// - rotation evaluated only at or above ten percent of nominal
module measuring_circuit_supervision
  import sup_pkg::*;
#(
  parameter int unsigned N_OC    = 8,
  parameter int unsigned N_EL    = 8,
  parameter int unsigned N_CT    = 1,
  parameter int unsigned N_VT    = 1,
  parameter int unsigned DELAY_W = 24
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  // measured magnitudes
  input  wire logic [MAG_W-1:0]        phase_volt_mag [3],
  input  wire logic [MAG_W-1:0]        residual_volt_mag,
  input  wire logic [MAG_W-1:0]        pos_seq_volt_mag,
  input  wire logic [MAG_W-1:0]        neg_seq_volt_mag,
  input  wire logic [MAG_W-1:0]        phase_curr_mag [3],
  input  wire logic [MAG_W-1:0]        residual_curr_mag,
  // ratings and settings
  input  wire logic [MAG_W-1:0]        volt_nominal,
  input  wire logic [MAG_W-1:0]        curr_rated,
  input  wire logic [MAG_W-1:0]        load_curr_threshold,
  input  wire logic [DELAY_W-1:0]      alarm_delay_cycles,
  input  wire logic                    potential_block_enable,
  // overcurrent pickups and their blocker selection
  input  wire logic [N_OC-1:0]         oc_pickup,
  input  wire logic [N_OC-1:0]         oc_blocker_sel,
  // breaker and offline detection
  input  wire logic                    breaker_assigned,
  input  wire logic                    breaker_closed,
  input  wire logic                    offline_dead_bus,
  // fuse failure inputs
  input  wire logic                    phase_vt_fuse_assigned,
  input  wire logic                    phase_vt_fuse_input,
  input  wire logic                    earth_vt_fuse_assigned,
  input  wire logic                    earth_vt_fuse_input,
  // protective element selection
  input  wire logic [N_EL-1:0]         element_sel,
  // ct supervision phasors and settings
  input  wire logic signed [MAG_W-1:0] phase_curr_re [3],
  input  wire logic signed [MAG_W-1:0] phase_curr_im [3],
  input  wire logic signed [MAG_W-1:0] earth_curr_re,
  input  wire logic signed [MAG_W-1:0] earth_curr_im,
  input  wire logic [MAG_W-1:0]        earth_ratio_factor,
  input  wire logic [MAG_W-1:0]        dynamic_correction_factor,
  input  wire logic [MAG_W-1:0]        ct_deviation,
  input  wire logic                    ct_supervision_enable,
  // phase rotation inputs
  input  wire logic [MAG_W-1:0]        ct_pos_seq [N_CT],
  input  wire logic [MAG_W-1:0]        ct_neg_seq [N_CT],
  input  wire logic [MAG_W-1:0]        vt_pos_seq [N_VT],
  input  wire logic [MAG_W-1:0]        vt_neg_seq [N_VT],
  input  wire logic                    rotation_setting_acb,
  // outputs
  output logic                         potential_loss_block,
  output logic [COND_N-1:0]            lop_condition_status,
  output logic                         fuse_failure_active,
  output logic [N_EL-1:0]              element_block,
  output logic                         ct_fault_alarm,
  output logic [N_CT-1:0]              ct_rotation_warn,
  output logic [N_VT-1:0]              vt_rotation_warn
);

  logic [COND_N-1:0]  cond_d;
  logic [COND_N-1:0]  cond_q;
  logic [DELAY_W-1:0] timer_q;
  logic [DELAY_W-1:0] timer_d;
  logic               block_q;
  logic               block_d;
  logic               fuse_q;
  logic               fuse_d;
  logic [N_EL-1:0]    elem_q;
  logic [N_EL-1:0]    elem_d;
  logic               all_cond;
  logic [MAG_W-1:0]   imax;
  logic               phase_low;
  logic               curr_low;

  // measured-quantity conditions
  always_comb begin
    phase_low = 1'b0;
    curr_low  = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (scaled_lt(phase_volt_mag[i], PCT_SCALE, volt_nominal, VOLT_LOSS_PCT)) begin
        phase_low = 1'b1;
      end
      if (phase_curr_mag[i] >= load_curr_threshold) begin
        curr_low = 1'b0;
      end
    end
  end

  always_comb begin
    cond_d                = COND_RESET;
    cond_d[COND_PHASE_V]  = phase_low;
    cond_d[COND_SEQ]      =
      scaled_lt(residual_volt_mag, PCT_SCALE, volt_nominal, RESID_VOLT_PCT) ||
      scaled_lt(pos_seq_volt_mag, NEG_POS_RATIO_PCT, neg_seq_volt_mag, PCT_SCALE);
    cond_d[COND_LOAD_I]   = curr_low;
    cond_d[COND_RESID_I]  =
      scaled_lt(residual_curr_mag, PCT_SCALE, curr_rated, RESID_CURR_PCT);
    cond_d[COND_NO_OC]    = ~|(oc_pickup & oc_blocker_sel);
    cond_d[COND_BREAKER]  = !breaker_assigned || breaker_closed;
    cond_d[COND_LIVE_BUS] = !offline_dead_bus;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cond_q <= COND_RESET;
    end else begin
      cond_q <= cond_d;
    end
  end

  assign all_cond = &cond_q;

  // persistence timer
  always_comb begin
    if (!all_cond) begin
      timer_d = '0;
    end else if (timer_q < alarm_delay_cycles) begin
      timer_d = timer_q + DELAY_W'(1);
    end else begin
      timer_d = timer_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_d;
    end
  end

  // potential loss block alarm
  assign block_d = all_cond && (timer_q >= alarm_delay_cycles);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else begin
      block_q <= block_d;
    end
  end

  // fuse failure digital inputs
  assign fuse_d = (phase_vt_fuse_assigned && phase_vt_fuse_input)
               || (earth_vt_fuse_assigned && earth_vt_fuse_input);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fuse_q <= 1'b0;
    end else begin
      fuse_q <= fuse_d;
    end
  end

  // element blocking
  always_comb begin
    elem_d = '0;
    if (potential_block_enable && block_q) begin
      elem_d = element_sel;
    end
    if (fuse_q) begin
      elem_d = element_sel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      elem_q <= '0;
    end else begin
      elem_q <= elem_d;
    end
  end

  // largest phase current for dynamic limit
  always_comb begin
    imax = phase_curr_mag[0];
    for (int i = 1; i < 3; i++) begin
      if (phase_curr_mag[i] > imax) begin
        imax = phase_curr_mag[i];
      end
    end
  end

  // ct earth current comparison
  ct_sum_if ct_bus ();

  assign ct_bus.phase_re                  = phase_curr_re;
  assign ct_bus.phase_im                  = phase_curr_im;
  assign ct_bus.earth_re                  = earth_curr_re;
  assign ct_bus.earth_im                  = earth_curr_im;
  assign ct_bus.earth_ratio_factor        = earth_ratio_factor;
  assign ct_bus.dynamic_correction_factor = dynamic_correction_factor;
  assign ct_bus.deviation                 = ct_deviation;
  assign ct_bus.imax                      = imax;
  assign ct_bus.enable                    = ct_supervision_enable;

  ct_sum_check u_ct_sum_check (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .bus     (ct_bus.chk)
  );

  // phase rotation per ct and vt
  rot_if #(.N(N_CT)) ct_rot ();
  rot_if #(.N(N_VT)) vt_rot ();

  assign ct_rot.pos_seq = ct_pos_seq;
  assign ct_rot.neg_seq = ct_neg_seq;
  assign ct_rot.nominal = curr_rated;
  assign ct_rot.setting = rotation_setting_acb ? ROT_ACB : ROT_ABC;
  assign vt_rot.pos_seq = vt_pos_seq;
  assign vt_rot.neg_seq = vt_neg_seq;
  assign vt_rot.nominal = volt_nominal;
  assign vt_rot.setting = rotation_setting_acb ? ROT_ACB : ROT_ABC;

  rotation_check #(.N(N_CT)) u_ct_rotation (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .bus     (ct_rot.chk)
  );

  rotation_check #(.N(N_VT)) u_vt_rotation (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .bus     (vt_rot.chk)
  );

  // outputs
  assign potential_loss_block = block_q;
  assign lop_condition_status = cond_q;
  assign fuse_failure_active  = fuse_q;
  assign element_block        = elem_q;
  assign ct_fault_alarm       = ct_bus.fault;
  assign ct_rotation_warn     = ct_rot.warn;
  assign vt_rotation_warn     = vt_rot.warn;

endmodule : measuring_circuit_supervision

`default_nettype wire

// [hw/rotation_check.sv]
// phase rotation warning per measuring input
`timescale 1ns/100ps
`default_nettype none

module rotation_check
  import sup_pkg::*;
#(
  parameter int unsigned N = 1
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  rot_if.chk        bus
);

  logic [N-1:0] warn_q;
  logic [N-1:0] warn_d;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      rotation_t        measured;
      logic [MAG_W-1:0] level;
      logic             valid;
      measured = (bus.pos_seq[i] >= bus.neg_seq[i]) ? ROT_ABC : ROT_ACB;
      level    = (bus.pos_seq[i] >= bus.neg_seq[i]) ? bus.pos_seq[i] : bus.neg_seq[i];
      valid    = !scaled_lt(level, PCT_SCALE, bus.nominal, ROT_MIN_PCT);
      warn_d[i] = valid && (measured != bus.setting);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      warn_q <= '0;
    end else begin
      warn_q <= warn_d;
    end
  end

  assign bus.warn = warn_q;

endmodule : rotation_check

`default_nettype wire

// [testbench/front_end_model.sv]
// front end model producing phase and sequence voltages
`timescale 1ns/100ps
`default_nettype none
module front_end_model
  import sup_pkg::*;
(
  input  wire logic [2:0]       lost,
  input  wire logic [MAG_W-1:0] vn,
  output logic      [MAG_W-1:0] vm [3],
  output logic      [MAG_W-1:0] v0,
  output logic      [MAG_W-1:0] v1,
  output logic      [MAG_W-1:0] v2
);
  int n;
  always_comb begin
    n = int'(lost[0]) + int'(lost[1]) + int'(lost[2]);
    for (int i = 0; i < 3; i++) begin
      vm[i] = lost[i] ? '0 : vn;
    end
    v1 = MAG_W'(vn * (3 - n) / 3);
    v2 = MAG_W'(vn * n / 3);
    v0 = v2;
  end
endmodule : front_end_model
`default_nettype wire

// [testbench/sup_chk.sv]
// assertions on the supervision top ports
`timescale 1ns/100ps
`default_nettype none
module sup_chk
  import sup_pkg::*;
#(
  parameter int unsigned N_OC    = 8,
  parameter int unsigned N_EL    = 8,
  parameter int unsigned DELAY_W = 24
) (
  input wire logic               sys_clk,
  input wire logic               reset_n,
  input wire logic [DELAY_W-1:0] alarm_delay_cycles,
  input wire logic               potential_block_enable,
  input wire logic [N_OC-1:0]    oc_pickup,
  input wire logic [N_OC-1:0]    oc_blocker_sel,
  input wire logic               breaker_assigned,
  input wire logic               offline_dead_bus,
  input wire logic               phase_vt_fuse_assigned,
  input wire logic               phase_vt_fuse_input,
  input wire logic               earth_vt_fuse_assigned,
  input wire logic               earth_vt_fuse_input,
  input wire logic [N_EL-1:0]    element_sel,
  input wire logic               potential_loss_block,
  input wire logic [COND_N-1:0]  lop_condition_status,
  input wire logic               fuse_failure_active,
  input wire logic [N_EL-1:0]    element_block,
  input wire logic               ct_fault_alarm
);
  int unsigned run_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // consecutive cycles with every condition met
  always_ff @(posedge sys_clk) begin
    if (!reset_n || lop_condition_status != 7'h7F) run_q <= 0;
    else run_q <= run_q + 1;
  end
  a_block_all_cond: assert property (potential_loss_block |-> $past(lop_condition_status) == 7'h7F)
    else $error("block without all conditions");
  a_delay_held: assert property (potential_loss_block |-> run_q >= alarm_delay_cycles)
    else $error("block before delay");
  a_block_drop: assert property (lop_condition_status != 7'h7F |=> !potential_loss_block)
    else $error("block kept after lapse");
  a_dead_bus: assert property (offline_dead_bus |=> !lop_condition_status[COND_LIVE_BUS])
    else $error("dead bus not seen");
  a_oc_blocker: assert property (|(oc_pickup & oc_blocker_sel) |=> !lop_condition_status[4])
    else $error("pickup did not suppress");
  a_breaker_free: assert property ($past(reset_n) && !breaker_assigned |=> lop_condition_status[5])
    else $error("unassigned breaker used");
  a_elem_select: assert property ((element_block & ~$past(element_sel)) == '0)
    else $error("unselected element blocked");
  a_fuse_set: assert property ($past(reset_n) && (phase_vt_fuse_assigned && phase_vt_fuse_input ||
    earth_vt_fuse_assigned && earth_vt_fuse_input) |=> fuse_failure_active)
    else $error("fuse failure missed");
  a_fuse_elem: assert property (fuse_failure_active |=> element_block == $past(element_sel))
    else $error("fuse did not block");
  a_enable_gate: assert property (!potential_block_enable && !fuse_failure_active |=> element_block == '0)
    else $error("block passed while disabled");
  c_block: cover property ($rose(potential_loss_block));
  c_fuse: cover property (fuse_failure_active && !potential_block_enable);
  c_ct: cover property ($rose(ct_fault_alarm));
endmodule : sup_chk
bind measuring_circuit_supervision sup_chk #(.N_OC(N_OC), .N_EL(N_EL), .DELAY_W(DELAY_W)) i_chk (
  .sys_clk, .reset_n, .alarm_delay_cycles, .potential_block_enable, .oc_pickup, .oc_blocker_sel,
  .breaker_assigned, .offline_dead_bus, .phase_vt_fuse_assigned, .phase_vt_fuse_input,
  .earth_vt_fuse_assigned, .earth_vt_fuse_input, .element_sel, .potential_loss_block,
  .lop_condition_status, .fuse_failure_active, .element_block, .ct_fault_alarm);
`default_nettype wire

// [testbench/test_measuring_circuit_supervision.sv]
// self-checking bench for measuring circuit supervision
`timescale 1ns/100ps
`default_nettype none
module test_measuring_circuit_supervision;
  import sup_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] r = 16'h005D;
  int error_cnt = 0;
  int checks_done = 0;
  logic [2:0] lost;
  logic [MAG_W-1:0] phase_volt_mag [3], phase_curr_mag [3], ct_pos_seq [1], ct_neg_seq [1];
  logic [MAG_W-1:0] vt_pos_seq [1], vt_neg_seq [1], residual_volt_mag, pos_seq_volt_mag;
  logic [MAG_W-1:0] neg_seq_volt_mag, residual_curr_mag, volt_nominal, curr_rated;
  logic [MAG_W-1:0] load_curr_threshold, earth_ratio_factor, dynamic_correction_factor, ct_deviation;
  logic signed [MAG_W-1:0] phase_curr_re [3], phase_curr_im [3], earth_curr_re, earth_curr_im;
  logic [23:0] alarm_delay_cycles;
  logic [7:0] oc_pickup, oc_blocker_sel, element_sel, element_block;
  logic [6:0] lop_condition_status;
  logic [0:0] ct_rotation_warn, vt_rotation_warn;
  logic potential_block_enable, breaker_assigned, breaker_closed, offline_dead_bus;
  logic phase_vt_fuse_assigned, phase_vt_fuse_input, earth_vt_fuse_assigned, earth_vt_fuse_input;
  logic ct_supervision_enable, rotation_setting_acb, potential_loss_block, fuse_failure_active;
  logic ct_fault_alarm;

  always #50 sys_clk = ~sys_clk;

  front_end_model i_fe (.lost(lost), .vn(volt_nominal), .vm(phase_volt_mag),
    .v0(residual_volt_mag), .v1(pos_seq_volt_mag), .v2(neg_seq_volt_mag));
  measuring_circuit_supervision i_dut (.sys_clk, .reset_n, .phase_volt_mag, .residual_volt_mag,
    .pos_seq_volt_mag, .neg_seq_volt_mag, .phase_curr_mag, .residual_curr_mag, .volt_nominal,
    .curr_rated, .load_curr_threshold, .alarm_delay_cycles, .potential_block_enable, .oc_pickup,
    .oc_blocker_sel, .breaker_assigned, .breaker_closed, .offline_dead_bus,
    .phase_vt_fuse_assigned, .phase_vt_fuse_input, .earth_vt_fuse_assigned, .earth_vt_fuse_input,
    .element_sel, .phase_curr_re, .phase_curr_im, .earth_curr_re, .earth_curr_im,
    .earth_ratio_factor, .dynamic_correction_factor, .ct_deviation, .ct_supervision_enable,
    .ct_pos_seq, .ct_neg_seq, .vt_pos_seq, .vt_neg_seq, .rotation_setting_acb,
    .potential_loss_block, .lop_condition_status, .fuse_failure_active, .element_block,
    .ct_fault_alarm, .ct_rotation_warn, .vt_rotation_warn);

  function automatic logic [15:0] lfsr();
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    return r;
  endfunction : lfsr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [6:0] m_status();
    logic [6:0] s;
    s = {!offline_dead_bus, !breaker_assigned || breaker_closed,
         !(|(oc_pickup & oc_blocker_sel)), residual_curr_mag * 100 < curr_rated * 10, 1'b1,
         residual_volt_mag * 100 < volt_nominal || neg_seq_volt_mag * 100 > pos_seq_volt_mag * 40,
         1'b0};
    for (int i = 0; i < 3; i++) begin
      if (phase_volt_mag[i] * 100 < volt_nominal) s[0] = 1'b1;
      if (phase_curr_mag[i] >= load_curr_threshold) s[2] = 1'b0;
    end
    return s;
  endfunction : m_status

  function automatic logic m_ct();
    longint re, im, mx, lim;
    re = (longint'(earth_curr_re) * longint'(earth_ratio_factor)) >>> 8;
    im = (longint'(earth_curr_im) * longint'(earth_ratio_factor)) >>> 8;
    mx = 0;
    for (int i = 0; i < 3; i++) begin
      re += phase_curr_re[i];
      im += phase_curr_im[i];
      if (phase_curr_mag[i] > mx) mx = phase_curr_mag[i];
    end
    lim = ct_deviation + ((mx * dynamic_correction_factor) >> 8);
    return ct_supervision_enable && re * re + im * im >= lim * lim;
  endfunction : m_ct

  function automatic logic m_rot(input logic [15:0] p, n, nom);
    logic [15:0] mx;
    mx = (p > n) ? p : n;
    return (mx * 100 >= nom * 10) && ((p < n) != rotation_setting_acb);
  endfunction : m_rot

  task automatic check_all();
    logic [6:0] s;
    logic f;
    s = m_status();
    f = phase_vt_fuse_assigned && phase_vt_fuse_input || earth_vt_fuse_assigned && earth_vt_fuse_input;
    chk(16'(lop_condition_status), 16'(s));
    chk(16'(potential_loss_block), 16'(&s));
    chk(16'(fuse_failure_active), 16'(f));
    chk(16'(element_block), (f || &s && potential_block_enable) ? 16'(element_sel) : 16'h0000);
    chk(16'(ct_fault_alarm), 16'(m_ct()));
    chk(16'(ct_rotation_warn), 16'(m_rot(ct_pos_seq[0], ct_neg_seq[0], curr_rated)));
    chk(16'(vt_rotation_warn), 16'(m_rot(vt_pos_seq[0], vt_neg_seq[0], volt_nominal)));
  endtask : check_all

  task automatic rnd_inputs();
    logic [15:0] a, b;
    a = lfsr();
    b = lfsr();
    lost = a[2:0];
    residual_curr_mag = a[3] ? 16'h0200 : 16'h0010;
    oc_pickup = b[7:0];
    oc_blocker_sel = a[4] ? b[15:8] : 8'h00;
    {breaker_assigned, breaker_closed, offline_dead_bus} = {a[5], a[6], a[7] & a[8]};
    {phase_vt_fuse_assigned, phase_vt_fuse_input} = {a[10] & a[9], a[9]};
    {earth_vt_fuse_assigned, earth_vt_fuse_input} = {a[12] & a[11], a[11]};
    {potential_block_enable, ct_supervision_enable, rotation_setting_acb} = a[15:13];
    earth_ratio_factor = b[0] ? 16'h0100 : 16'h0200;
    dynamic_correction_factor = {8'h00, b[15:8]};
    element_sel = b[7:0] ^ a[7:0];
    for (int i = 0; i < 4; i++) begin
      a = lfsr();
      if (i < 3) begin
        phase_curr_mag[i] = (a[9] & a[10]) ? 16'h0400 : 16'h0100;
        phase_curr_re[i] = {{7{a[8]}}, a[8:0]};
        phase_curr_im[i] = {{7{a[15]}}, a[15:7]};
      end
    end
    earth_curr_re = {{7{a[3]}}, a[3:0], a[15:11]};
    earth_curr_im = {{7{b[4]}}, b[4:0], a[10:7]};
    b = lfsr();
    {ct_pos_seq[0], ct_neg_seq[0]} = {5'h00, a[10:0], 5'h00, b[10:0]};
    {vt_pos_seq[0], vt_neg_seq[0]} = {5'h00, b[15:5], 5'h00, a[15:5]};
  endtask : rnd_inputs

  task automatic delay_test(input int d);
    int n;
    lost = 3'b010;
    residual_curr_mag = 16'h0010;
    oc_blocker_sel = 8'h00;
    {breaker_assigned, breaker_closed, offline_dead_bus} = 3'b111;
    {phase_vt_fuse_assigned, earth_vt_fuse_assigned} = 2'b00;
    {phase_vt_fuse_input, earth_vt_fuse_input, potential_block_enable} = 3'b111;
    alarm_delay_cycles = 24'(d);
    phase_curr_mag = '{3{16'h0100}};
    repeat (4) @(negedge sys_clk);
    n = 0;
    offline_dead_bus = 1'b0;
    while (potential_loss_block !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(n), 16'(d + 2));
    if (n >= 40) final_report();
    @(negedge sys_clk);
    chk(16'(element_block), 16'(element_sel));
    offline_dead_bus = 1'b1;
    @(negedge sys_clk);
    chk(16'(potential_loss_block), 16'h0001);
    @(negedge sys_clk);
    chk(16'(potential_loss_block), 16'h0000);
    $display("delay test %0d done", d);
  endtask : delay_test

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    {volt_nominal, curr_rated, load_curr_threshold} = {16'h1000, 16'h0400, 16'h0200};
    ct_deviation = 16'h0100;
    alarm_delay_cycles = 24'h000001;
    rnd_inputs();
    repeat (20) @(negedge sys_clk);
    chk({1'b0, lop_condition_status, element_block}, 16'h0000);
    chk(16'({potential_loss_block, fuse_failure_active, ct_fault_alarm}), 16'h0000);
    reset_n = 1'b1;
    $display("reset test done");
    for (int t = 0; t < 80; t++) begin
      rnd_inputs();
      repeat (7) @(negedge sys_clk);
      check_all();
    end
    $display("random test done");
    delay_test(0);
    delay_test(2);
    delay_test(5);
    final_report();
  end
endmodule : test_measuring_circuit_supervision
`default_nettype wire
